// [core/scr_defs.vh]
`ifndef SCR_DEFS_VH
`define SCR_DEFS_VH

// Strap group width and ratio encodings
`define SCR_STRAP_W 3
// Ratio fields are 5 bits; core ratios are reported as numerator/denominator
`define SCR_RAT_W 5

// Platform:reference ratio codes
`define SCR_PLAT_4 3'h0
`define SCR_PLAT_5 3'h1
`define SCR_PLAT_6 3'h2
`define SCR_PLAT_8 3'h3
`define SCR_PLAT_10 3'h4
`define SCR_PLAT_12 3'h5

// Core:platform ratio codes
`define SCR_CORE_3_2 3'h3
`define SCR_CORE_2_1 3'h4
`define SCR_CORE_5_2 3'h5
`define SCR_CORE_3_1 3'h6
`define SCR_CORE_7_2 3'h7

// Memory data rate:memory reference ratio codes
`define SCR_MEM_3 3'h0
`define SCR_MEM_4 3'h1
`define SCR_MEM_6 3'h2
`define SCR_MEM_8 3'h3
`define SCR_MEM_10 3'h4
`define SCR_MEM_12 3'h5
`define SCR_MEM_14 3'h6
`define SCR_MEM_SYNC 3'h7

// Numerator and denominator constants
`define SCR_N0 5'h00
`define SCR_N1 5'h01
`define SCR_N2 5'h02
`define SCR_N3 5'h03
`define SCR_N4 5'h04
`define SCR_N5 5'h05
`define SCR_N6 5'h06
`define SCR_N7 5'h07
`define SCR_N8 5'h08
`define SCR_N10 5'h0A
`define SCR_N12 5'h0C
`define SCR_N14 5'h0E

// Memory bus clock is the data rate divided by this
`define SCR_MCK_DIV 5'h02

`endif

// [core/scr_core_ratio.v]
`timescale 1ns/1ps
`default_nettype none
`include "scr_defs.vh"

// Core:platform decode, shared by both core strap groups
module scr_core_ratio
(
	input wire [`SCR_STRAP_W-1:0] code,
	output reg [`SCR_RAT_W-1:0] num,
	output reg [`SCR_RAT_W-1:0] den,
	output reg bad
);
	always @*
	begin
		num = `SCR_N0;
		den = `SCR_N1;
		bad = 1'b0;
		case (code)
			`SCR_CORE_3_2:
			begin
				num = `SCR_N3;
				den = `SCR_N2;
			end
			`SCR_CORE_2_1:
			begin
				num = `SCR_N2;
				den = `SCR_N1;
			end
			`SCR_CORE_5_2:
			begin
				num = `SCR_N5;
				den = `SCR_N2;
			end
			`SCR_CORE_3_1:
			begin
				num = `SCR_N3;
				den = `SCR_N1;
			end
			`SCR_CORE_7_2:
			begin
				num = `SCR_N7;
				den = `SCR_N2;
			end
			default:
				bad = 1'b1; // Reserved 000..010
		endcase
	end
endmodule
`default_nettype wire

// [core/scr_strap_cfg.v]
`timescale 1ns/1ps
`default_nettype none
`include "scr_defs.vh"

module scr_strap_cfg
(
	input wire core_clk,
	input wire rst,
	input wire clk_en,
	input wire [`SCR_STRAP_W-1:0] platform_ratio_strap,
	input wire core0_ratio_strap_msb,
	input wire core0_ratio_strap_mid,
	input wire core0_ratio_strap_lsb,
	input wire core1_ratio_strap_msb,
	input wire core1_ratio_strap_mid,
	input wire core1_ratio_strap_lsb,
	input wire memory_ratio_strap_msb,
	input wire memory_ratio_strap_mid,
	input wire memory_ratio_strap_lsb,
	output reg cfg_valid,
	output reg cfg_invalid,
	output reg [`SCR_RAT_W-1:0] plat_ratio,
	output reg [`SCR_RAT_W-1:0] core0_ratio_num,
	output reg [`SCR_RAT_W-1:0] core0_ratio_den,
	output reg [`SCR_RAT_W-1:0] core1_ratio_num,
	output reg [`SCR_RAT_W-1:0] core1_ratio_den,
	output reg mem_async,
	output reg [`SCR_RAT_W-1:0] mem_ratio,
	output reg [`SCR_RAT_W-1:0] mck_div,
	output reg plat_bad,
	output reg core0_bad,
	output reg core1_bad
);
	wire [`SCR_STRAP_W-1:0] core0_code;
	wire [`SCR_STRAP_W-1:0] core1_code;
	wire [`SCR_STRAP_W-1:0] mem_code;
	wire [`SCR_RAT_W-1:0] c0_num;
	wire [`SCR_RAT_W-1:0] c0_den;
	wire [`SCR_RAT_W-1:0] c1_num;
	wire [`SCR_RAT_W-1:0] c1_den;
	wire c0_bad;
	wire c1_bad;
	reg [`SCR_RAT_W-1:0] next_plat;
	reg next_plat_bad;
	reg [`SCR_RAT_W-1:0] next_mem;
	reg next_async;
	reg [1:0] state;
	reg [1:0] next_state;
	wire capture;

	// One-hot capture sequencer
	localparam ST_WAIT = 2'b01;
	localparam ST_HELD = 2'b10;

	assign core0_code = {core0_ratio_strap_msb, core0_ratio_strap_mid,
		core0_ratio_strap_lsb};
	assign core1_code = {core1_ratio_strap_msb, core1_ratio_strap_mid,
		core1_ratio_strap_lsb};
	assign mem_code = {memory_ratio_strap_msb, memory_ratio_strap_mid,
		memory_ratio_strap_lsb};

	// Two instances, no shared state between cores
	scr_core_ratio u_core0
	(
		.code(core0_code),
		.num(c0_num),
		.den(c0_den),
		.bad(c0_bad)
	);

	scr_core_ratio u_core1
	(
		.code(core1_code),
		.num(c1_num),
		.den(c1_den),
		.bad(c1_bad)
	);

	always @*
	begin
		next_plat = `SCR_N0;
		next_plat_bad = 1'b0;
		case (platform_ratio_strap)
			`SCR_PLAT_4:
			begin
				next_plat = `SCR_N4;
			end
			`SCR_PLAT_5:
			begin
				next_plat = `SCR_N5;
			end
			`SCR_PLAT_6:
			begin
				next_plat = `SCR_N6;
			end
			`SCR_PLAT_8:
			begin
				next_plat = `SCR_N8;
			end
			`SCR_PLAT_10:
			begin
				next_plat = `SCR_N10;
			end
			`SCR_PLAT_12:
			begin
				next_plat = `SCR_N12;
			end
			default:
			begin
				next_plat_bad = 1'b1;
			end
		endcase
	end

	always @*
	begin
		next_mem = `SCR_N0;
		next_async = 1'b1;
		case (mem_code)
			`SCR_MEM_3:
			begin
				next_mem = `SCR_N3;
			end
			`SCR_MEM_4:
			begin
				next_mem = `SCR_N4;
			end
			`SCR_MEM_6:
			begin
				next_mem = `SCR_N6;
			end
			`SCR_MEM_8:
			begin
				next_mem = `SCR_N8;
			end
			`SCR_MEM_10:
			begin
				next_mem = `SCR_N10;
			end
			`SCR_MEM_12:
			begin
				next_mem = `SCR_N12;
			end
			`SCR_MEM_14:
			begin
				next_mem = `SCR_N14;
			end
			default:
			begin
				next_async = 1'b0; // Synchronous selection
			end
		endcase
	end

	// Capture only once per reset, even if clk_en toggles later
	always @*
	begin
		next_state = state;
		case (state)
			ST_WAIT:
				next_state = ST_HELD;
			ST_HELD:
				next_state = ST_HELD;
			default:
				next_state = ST_WAIT;
		endcase
	end

	assign capture = (state == ST_WAIT);

	// Straps are caught on the first enabled edge after release, then frozen
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			state <= ST_WAIT;
			cfg_valid <= 1'b0;
			cfg_invalid <= 1'b0;
			plat_ratio <= `SCR_N0;
			core0_ratio_num <= `SCR_N0;
			core0_ratio_den <= `SCR_N1;
			core1_ratio_num <= `SCR_N0;
			core1_ratio_den <= `SCR_N1;
			mem_async <= 1'b0;
			mem_ratio <= `SCR_N0;
			mck_div <= `SCR_MCK_DIV;
			plat_bad <= 1'b0;
			core0_bad <= 1'b0;
			core1_bad <= 1'b0;
		end
		else if (clk_en)
		begin
			state <= next_state;
			if (capture)
			begin
				// No default on a reserved code; only the flag tells
				plat_ratio <= next_plat;
				plat_bad <= next_plat_bad;
				core0_ratio_num <= c0_num;
				core0_ratio_den <= c0_den;
				core1_ratio_num <= c1_num;
				core1_ratio_den <= c1_den;
				core0_bad <= c0_bad;
				core1_bad <= c1_bad;
				// Single mode flag drives both controllers
				mem_async <= next_async;
				// Sync: data rate equals platform, ratio 1
				mem_ratio <= next_async ? next_mem : `SCR_N1;
				mck_div <= `SCR_MCK_DIV;
				cfg_invalid <= next_plat_bad | c0_bad | c1_bad;
				cfg_valid <= ~(next_plat_bad | c0_bad | c1_bad);
			end
		end
	end
endmodule
`default_nettype wire

// [testbench/scr_strap_cfg_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module scr_mon
(
	input wire core_clk,
	input wire rst,
	input wire clk_en,
	input wire [2:0] platform_ratio_strap,
	input wire cfg_valid,
	input wire cfg_invalid,
	input wire plat_bad,
	input wire core0_bad,
	input wire core1_bad,
	input wire [4:0] plat_ratio,
	input wire [4:0] mck_div,
	input wire mem_async,
	input wire [4:0] mem_ratio
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire done = cfg_valid | cfg_invalid;
	wire cap = !done && clk_en;
	property p_cap; cap |=> cfg_valid ^ cfg_invalid; endproperty
	a_cap: assert property (p_cap) else $error("no capture");
	property p_frz; !done && !clk_en |=> !done; endproperty
	a_frz: assert property (p_frz) else $error("early capture");
	property p_hold; done |=> $stable({plat_ratio, mem_ratio, done}); endproperty
	a_hold: assert property (p_hold) else $error("ratio moved");
	property p_bad; done |-> cfg_invalid == (plat_bad|core0_bad|core1_bad);
	endproperty
	a_bad: assert property (p_bad) else $error("flag mismatch");
	property p_pres; cap && platform_ratio_strap > 3'h5 |=> plat_bad;
	endproperty
	a_pres: assert property (p_pres) else $error("reserved missed");
	property p_p12; cap && platform_ratio_strap == 3'h5 |=> plat_ratio == 5'h0C;
	endproperty
	a_p12: assert property (p_p12) else $error("ratio not 12");
	property p_mck; mck_div == 5'h02; endproperty
	a_mck: assert property (p_mck) else $error("bad divider");
	property p_sync; done && !mem_async |-> mem_ratio == 5'h01; endproperty
	a_sync: assert property (p_sync) else $error("sync ratio");
	property p_asy; done && mem_async |-> mem_ratio > 5'h02; endproperty
	a_asy: assert property (p_asy) else $error("async ratio");
endmodule
bind scr_strap_cfg scr_mon u_mon (.core_clk(core_clk), .rst(rst),
	.clk_en(clk_en), .platform_ratio_strap(platform_ratio_strap),
	.cfg_valid(cfg_valid), .cfg_invalid(cfg_invalid), .plat_bad(plat_bad),
	.core0_bad(core0_bad), .core1_bad(core1_bad), .plat_ratio(plat_ratio),
	.mck_div(mck_div), .mem_async(mem_async), .mem_ratio(mem_ratio));
`default_nettype wire

// [testbench/scr_board.sv]
`timescale 1ns/1ps
`default_nettype none
module scr_board
(
	input wire [11:0] cfg,
	input wire busy,
	input wire [11:0] junk,
	output logic [11:0] pins
);
	// Straps hold while busy is low; once busy is set the shared pins carry traffic
	assign pins = busy ? junk : cfg;
endmodule
`default_nettype wire

// [testbench/scr_strap_cfg_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(e, s) begin compares++; if ((e) !== (s)) begin num_errors++; \
	$display("mismatch cfg exp %h got %h", e, s); end end
module scr_strap_cfg_tb;
	logic core_clk = 0, rst = 1, clk_en = 0, busy = 0, look = 0;
	logic [11:0] cfg = 0, junk = 0;
	logic [40:0] q[$], e, got;
	wire [11:0] p;
	wire cfg_valid, cfg_invalid, plat_bad, core0_bad, core1_bad, mem_async;
	wire [4:0] plat_ratio, core0_ratio_num, core0_ratio_den;
	wire [4:0] core1_ratio_num, core1_ratio_den, mem_ratio, mck_div;
	int num_errors = 0, compares = 0, seed = 32'h9719AA10, n;
	logic [4:0] pt[8] = '{5'h04, 5'h05, 5'h06, 5'h08, 5'h0A, 5'h0C, 0, 0};
	logic [4:0] cn[8] = '{0, 0, 0, 5'h03, 5'h02, 5'h05, 5'h03, 5'h07};
	logic [4:0] cd[8] = '{1, 1, 1, 5'h02, 5'h01, 5'h02, 5'h01, 5'h02};
	logic [4:0] mt[8] = '{5'h03, 5'h04, 5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E, 1};
	scr_board u_scr_board (.cfg(cfg), .busy(busy), .junk(junk), .pins(p));
	scr_strap_cfg u_scr_strap_cfg (.core_clk(core_clk), .rst(rst),
		.clk_en(clk_en), .platform_ratio_strap(p[11:9]),
		.core0_ratio_strap_msb(p[8]), .core0_ratio_strap_mid(p[7]),
		.core0_ratio_strap_lsb(p[6]), .core1_ratio_strap_msb(p[5]),
		.core1_ratio_strap_mid(p[4]), .core1_ratio_strap_lsb(p[3]),
		.memory_ratio_strap_msb(p[2]), .memory_ratio_strap_mid(p[1]),
		.memory_ratio_strap_lsb(p[0]), .cfg_valid(cfg_valid),
		.cfg_invalid(cfg_invalid), .plat_ratio(plat_ratio),
		.core0_ratio_num(core0_ratio_num), .core0_ratio_den(core0_ratio_den),
		.core1_ratio_num(core1_ratio_num), .core1_ratio_den(core1_ratio_den),
		.mem_async(mem_async), .mem_ratio(mem_ratio), .mck_div(mck_div),
		.plat_bad(plat_bad), .core0_bad(core0_bad), .core1_bad(core1_bad));
	initial forever #2.5 core_clk = ~core_clk;
	function automatic logic [40:0] ex(logic [11:0] c);
		logic b0, b1, b2;
		b0 = c[11:10] == 2'h3;
		b1 = c[8:6] < 3'h3;
		b2 = c[5:3] < 3'h3;
		return {!(b0|b1|b2), b0|b1|b2, b0, b1, b2, pt[c[11:9]], cn[c[8:6]],
			cd[c[8:6]], cn[c[5:3]], cd[c[5:3]], c[2:0] != 3'h7, mt[c[2:0]], 5'h02};
	endfunction
	always @(posedge core_clk)
		if (look)
		begin
			e = q.pop_front();
			got = {cfg_valid, cfg_invalid, plat_bad, core0_bad, core1_bad,
				plat_ratio, core0_ratio_num, core0_ratio_den, core1_ratio_num,
				core1_ratio_den, mem_async, mem_ratio, mck_div};
			`CHK(e, got)
		end
	task complete_run;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic note(logic [11:0] c);
		q.push_back(ex(c));
		look = 1;
		@(posedge core_clk) #1 look = 0;
	endtask
	task automatic go(logic [11:0] c);
		@(posedge core_clk) #1 rst = 1;
		cfg = c;
		busy = 0;
		clk_en = 0;
		repeat (2) @(posedge core_clk);
		#1 rst = 0;
		// Random hold-off with the enable low checks the freeze
		repeat ({$random(seed)} % 4) @(posedge core_clk);
		#1 clk_en = 1;
		for (n = 0; !(cfg_valid | cfg_invalid); n++)
		begin
			if (n == 8)
			begin
				num_errors++;
				complete_run;
			end
			@(posedge core_clk) #1;
		end
		note(c);
		busy = 1;
		repeat (3) @(posedge core_clk) #1 junk = 12'($random(seed));
		note(c);
		$display("test %h done", c);
	endtask
	initial
	begin
		repeat (16) @(posedge core_clk);
		// Straps a 100 MHz reference board would use, all rates in range
		go(12'h137);
		go(12'h1EB);
		for (int i = 0; i < 8; i++)
			go({i[2:0], i[2:0], 3'h7 - i[2:0], i[2:0]});
		repeat (20) go(12'($random(seed)));
		complete_run;
	end
endmodule
`default_nettype wire
